// file: usb_dr_params.svh
// offsets, field positions, reset values and timing counts of the usb core
// assumes a 32-bit register port with byte addresses in the low 8 bits
`ifndef USB_DR_PARAMS_SVH
`define USB_DR_PARAMS_SVH

`define MEM_WORDS        320
`define MEM_AW           9
`define CLK_PERIOD_NS    100
`define SUSPEND_IDLE_NS  3000000
`define SUSPEND_CYCLES   ((`SUSPEND_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_NS         1000000
`define FRAME_CYCLES     (`FRAME_NS / `CLK_PERIOD_NS)
`define DEV_TX_FIFOS     8
`define HOST_TX_FIFOS    2
`define DEV_IN_EPS       4'h7
`define DEV_OUT_EPS      4'h7
`define HOST_CHANNELS    5'h10

`define OFS_GBUS_CFG     8'h00
`define OFS_USB_CFG      8'h04
`define OFS_RESET_CTL    8'h08
`define OFS_IRQ_MASK     8'h0C
`define OFS_IRQ_STATUS   8'h10
`define OFS_RX_POP       8'h14
`define OFS_RX_SIZE      8'h18
`define OFS_TX_PUSH      8'h1C
`define OFS_TX_SELECT    8'h20
`define OFS_CORE_CFG     8'h24
`define OFS_PHY_GATE     8'h28
`define OFS_EP_CTL       8'h2C
`define OFS_INFO         8'h30
`define OFS_TX_SIZE0     8'h40

`define GBUS_CFG_MASK    32'h0000_0181
`define USB_CFG_MASK     32'h0001_3C07
`define IRQ_MASK_MASK    32'h0000_0016
`define IRQ_MASK_RESET   32'h0000_0016
`define USB_CFG_LS_BIT   16
`define RST_RX_FLUSH     4
`define RST_TX_FLUSH     5
`define RST_SEL_LO       6
`define TX_SEL_ALL       5'h10
`define ST_ROLE          0
`define ST_MISMATCH      1
`define ST_ROLE_CHG      2
`define ST_SUSPEND       3
`define ST_ALLOC_ERR     4
`define ST_RX_AVAIL      5
`define ST_LOW_SPEED     6

`endif

// file: usb_dr_pkg.sv
// types shared by the usb dual role core and its peer model
// constants live in usb_dr_params.svh
package usb_dr_pkg;
	typedef enum logic {ROLE_DEVICE, ROLE_HOST} role_t;
	typedef struct packed {
		logic [8:0] depth;
		logic [8:0] start;
	} fifo_cfg_t;
	typedef struct packed {
		logic [31:0] data;
		logic        last;
		logic [3:0]  ep;
	} rx_word_t;
endpackage

// file: usb_packet_ram.sv
// packet memory: one write port, one read port, registered read data
// assumes a single clock shared with the core
`timescale 1ns/1ns
module usb_packet_ram #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 320,
	parameter int AW    = 9
) (
	input  wire logic             core_clk_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic             re_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("packet ram depth exceeds address width");
	end

	always_ff @(posedge core_clk_i) begin
		if (we_i)
			mem_q[waddr_i] <= wdata_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (re_i)
			rdata_o <= mem_q[raddr_i];
	end
endmodule // usb_packet_ram

// file: usb_dual_role_core.sv
// usb dual role core: role, frame pulses, suspend and packet fifos
// assumes link logic on core_clk_i; pins pass a two flop synchroniser
`timescale 1ns/1ns
`include "usb_dr_params.svh"

// What this block does
// - floating id gives device, grounded gives host
// - host full or low speed, device full only
// - device eight endpoints, host sixteen channels
// - all fifos live in 1280 byte memory
// - frame start pulse to pin and timer
// - output enable pulse while driving lines
// - device: shared receive, per endpoint transmit
// - host: shared receive, nonperiodic, periodic transmit
// - stop clock bit plus 3 ms idle suspends
// - low power bit turns phy receiver off
// - line sampling and registers both on core_clk_i
// - role flag set from plug at power on
// - status word written after each packet
module usb_dual_role_core #(
	parameter int MEM_WORDS      = `MEM_WORDS,
	parameter int SUSPEND_CYCLES = `SUSPEND_CYCLES,
	parameter int FRAME_CYCLES   = `FRAME_CYCLES
) (
	input  wire logic                core_clk_i,
	input  wire logic                rst_i,
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [31:0]         reg_rdata_o,
	input  wire logic                role_select_pin_i,
	input  wire logic                line_activity_pin_i,
	input  wire logic                rx_valid_i,
	input  wire usb_dr_pkg::rx_word_t rx_word_i,
	output logic                     rx_ready_o,
	input  wire logic                tx_rd_i,
	input  wire logic [3:0]          tx_sel_i,
	output logic                     tx_rd_ready_o,
	output logic                     tx_valid_o,
	output logic      [31:0]         tx_data_o,
	input  wire logic                tx_drive_i,
	input  wire logic                sof_token_i,
	output logic                     frame_start_pulse_pin_o,
	output logic                     sof_timer_pulse_o,
	output logic                     output_enable_pulse_pin_o,
	output logic                     host_role_o,
	output logic                     link_low_speed_o,
	output logic                     phy_rx_enable_o,
	output logic                     suspend_o
);
	localparam int NF = `DEV_TX_FIFOS;

	if (MEM_WORDS > (1 << `MEM_AW) || SUSPEND_CYCLES < 1 ||
	    FRAME_CYCLES < 2 || SUSPEND_CYCLES >= (1 << 20) ||
	    FRAME_CYCLES >= (1 << 20)) begin : g_chk
		$error("usb_dual_role_core parameters out of range");
	end

	function automatic logic [8:0] fifo_addr(input logic [8:0] start,
	                                         input logic [8:0] ptr);
		return 9'(start + ptr);
	endfunction

	function automatic logic [8:0] ptr_inc(input logic [8:0] ptr,
	                                       input logic [8:0] depth);
		return (9'(ptr + 9'h001) >= depth) ? 9'h000 : 9'(ptr + 9'h001);
	endfunction

	// synchronisers for pins from the line side
	logic [1:0] id_sync_q;
	logic [2:0] act_sync_q;
	// id sync runs through reset so the role latch sees a settled pin
	always_ff @(posedge core_clk_i) begin
		id_sync_q <= {id_sync_q[0], role_select_pin_i};
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			act_sync_q <= 3'h0;
		else
			act_sync_q <= {act_sync_q[1:0], line_activity_pin_i};
	end
	wire line_act = act_sync_q[2] ^ act_sync_q[1];
	wire pin_host = ~id_sync_q[1];

	// role latched once after reset release, as at power on
	usb_dr_pkg::role_t role_q;
	logic              role_valid_q;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			role_q       <= usb_dr_pkg::ROLE_DEVICE;
			role_valid_q <= 1'b0;
		end else if (!role_valid_q) begin
			role_valid_q <= 1'b1;
			role_q <= pin_host ? usb_dr_pkg::ROLE_HOST
			                   : usb_dr_pkg::ROLE_DEVICE;
		end
	end
	wire is_host = (role_q == usb_dr_pkg::ROLE_HOST);
	wire [3:0] n_tx = is_host ? 4'(`HOST_TX_FIFOS)
	                          : 4'(`DEV_TX_FIFOS);

	// software registers
	logic [31:0] gbus_cfg_q;
	logic [31:0] usb_cfg_q;
	logic [31:0] irq_mask_q;
	logic        rx_flush_q;
	logic        tx_flush_q;
	logic [4:0]  flush_sel_q;
	logic [3:0]  tx_select_q;
	logic        phy_receive_off_bit;
	logic        stop_phy_clock_bit;
	logic [7:0]  ep_enable_q;
	logic [7:0]  ep_nak_q;
	logic [8:0]  rx_depth_q;
	logic        mismatch_q;
	logic        role_chg_q;
	usb_dr_pkg::fifo_cfg_t tx_cfg_q [NF];

	wire wr_hit_gbus = reg_wr_i && reg_addr_i == `OFS_GBUS_CFG;
	wire wr_hit_usb  = reg_wr_i && reg_addr_i == `OFS_USB_CFG;
	wire wr_hit_rst  = reg_wr_i && reg_addr_i == `OFS_RESET_CTL;
	wire wr_hit_mask = reg_wr_i && reg_addr_i == `OFS_IRQ_MASK;
	wire wr_hit_stat = reg_wr_i && reg_addr_i == `OFS_IRQ_STATUS;
	wire wr_hit_rxsz = reg_wr_i && reg_addr_i == `OFS_RX_SIZE;
	wire wr_hit_push = reg_wr_i && reg_addr_i == `OFS_TX_PUSH;
	wire wr_hit_sel  = reg_wr_i && reg_addr_i == `OFS_TX_SELECT;
	wire wr_hit_core = reg_wr_i && reg_addr_i == `OFS_CORE_CFG;
	wire wr_hit_gate = reg_wr_i && reg_addr_i == `OFS_PHY_GATE;
	wire wr_hit_ep   = reg_wr_i && reg_addr_i == `OFS_EP_CTL;
	wire wr_hit_txsz = reg_wr_i && reg_addr_i[7:5] == 3'h2 &&
	                   reg_addr_i[1:0] == 2'h0;
	wire [2:0] txsz_idx = reg_addr_i[4:2];
	// a live resize would corrupt pointers of an active endpoint
	wire resize_safe = (ep_enable_q == 8'h00) && (&ep_nak_q);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			gbus_cfg_q          <= 32'h0000_0000;
			usb_cfg_q           <= 32'h0000_0000;
			irq_mask_q          <= `IRQ_MASK_RESET;
			tx_select_q         <= 4'h0;
			phy_receive_off_bit <= 1'b0;
			stop_phy_clock_bit  <= 1'b0;
			ep_enable_q         <= 8'h00;
			ep_nak_q            <= 8'hFF;
		end else begin
			if (wr_hit_gbus)
				gbus_cfg_q <= reg_wdata_i & `GBUS_CFG_MASK;
			if (wr_hit_usb)
				usb_cfg_q <= reg_wdata_i & `USB_CFG_MASK;
			if (wr_hit_mask)
				irq_mask_q <= reg_wdata_i & `IRQ_MASK_MASK;
			if (wr_hit_sel)
				tx_select_q <= reg_wdata_i[3:0];
			if (wr_hit_core)
				phy_receive_off_bit <= reg_wdata_i[0];
			if (wr_hit_gate)
				stop_phy_clock_bit <= reg_wdata_i[0];
			if (wr_hit_ep && !is_host) begin
				ep_enable_q <= reg_wdata_i[7:0];
				ep_nak_q    <= reg_wdata_i[15:8];
			end
		end
	end

	// fifo split, counted in words
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_depth_q <= 9'h000;
			for (int i = 0; i < NF; i++)
				tx_cfg_q[i] <= '0;
		end else begin
			if (wr_hit_rxsz && resize_safe)
				rx_depth_q <= reg_wdata_i[8:0];
			if (wr_hit_txsz && resize_safe)
				tx_cfg_q[txsz_idx] <= '{depth: reg_wdata_i[24:16],
				                       start: reg_wdata_i[8:0]};
		end
	end

	// the receive region or a transmit region in use by the role past the end of packet memory flags the split as bad
	logic alloc_err;
	always_comb begin
		alloc_err = 32'(rx_depth_q) > MEM_WORDS;
		for (int i = 0; i < NF; i++) begin
			if (4'(i) < n_tx && 32'(tx_cfg_q[i].start) +
			    32'(tx_cfg_q[i].depth) > MEM_WORDS)
				alloc_err = 1'b1;
		end
	end

	// receive fifo pointers, region starts at word zero
	logic [8:0] rx_wp_q;
	logic [8:0] rx_rp_q;
	logic [8:0] rx_cnt_q;
	logic [8:0] pkt_len_q;
	logic [3:0] pkt_ep_q;
	logic       status_pend_q;
	logic [8:0] tx_wp_q  [NF];
	logic [8:0] tx_rp_q  [NF];
	logic [8:0] tx_cnt_q [NF];

	wire sel_ok    = tx_select_q < n_tx;
	wire [2:0] sel = tx_select_q[2:0];
	wire push_room = tx_cnt_q[sel] < tx_cfg_q[sel].depth;
	wire sw_push   = wr_hit_push && sel_ok && push_room;
	wire status_wr = status_pend_q && !sw_push;
	// one word kept free so the status word always fits behind the data
	wire rx_room   = 10'({1'b0, rx_cnt_q}) + 10'h002 <=
	                 10'({1'b0, rx_depth_q});
	wire flushing  = rx_flush_q || tx_flush_q;
	assign rx_ready_o = rx_room && !status_pend_q && !sw_push &&
	                    !phy_receive_off_bit && !flushing &&
	                    !alloc_err;
	wire rx_take   = rx_valid_i && rx_ready_o;

	wire pop_rd    = reg_rd_i && reg_addr_i == `OFS_RX_POP;
	wire pop_ok    = pop_rd && rx_cnt_q != 9'h000;
	wire [2:0] tsel = tx_sel_i[2:0];
	assign tx_rd_ready_o = !pop_rd;
	wire tx_take   = tx_rd_i && tx_rd_ready_o && tx_sel_i < n_tx &&
	                 tx_cnt_q[tsel] != 9'h000;

	wire        mem_we    = sw_push || status_wr || rx_take;
	wire [8:0]  mem_waddr = sw_push ?
	                        fifo_addr(tx_cfg_q[sel].start, tx_wp_q[sel]) :
	                        rx_wp_q;
	wire [31:0] stat_word = {19'h0, pkt_len_q, pkt_ep_q};
	wire [31:0] mem_wdata = sw_push ? reg_wdata_i :
	                        status_wr ? stat_word : rx_word_i.data;
	wire        mem_re    = pop_ok || tx_take;
	wire [8:0]  mem_raddr = pop_ok ? rx_rp_q :
	                        fifo_addr(tx_cfg_q[tsel].start, tx_rp_q[tsel]);
	logic [31:0] mem_rdata;

	usb_packet_ram #(
		.WIDTH (32),
		.DEPTH (MEM_WORDS),
		.AW    (`MEM_AW)
	) u_ram (
		.core_clk_i (core_clk_i),
		.we_i       (mem_we),
		.waddr_i    (mem_waddr),
		.wdata_i    (mem_wdata),
		.re_i       (mem_re),
		.raddr_i    (mem_raddr),
		.rdata_o    (mem_rdata)
	);

	wire rx_in = rx_take || status_wr;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_wp_q       <= 9'h000;
			rx_rp_q       <= 9'h000;
			rx_cnt_q      <= 9'h000;
			pkt_len_q     <= 9'h000;
			pkt_ep_q      <= 4'h0;
			status_pend_q <= 1'b0;
		end else if (rx_flush_q) begin
			rx_wp_q       <= 9'h000;
			rx_rp_q       <= 9'h000;
			rx_cnt_q      <= 9'h000;
			pkt_len_q     <= 9'h000;
			status_pend_q <= 1'b0;
		end else begin
			if (rx_in)
				rx_wp_q <= ptr_inc(rx_wp_q, rx_depth_q);
			if (pop_ok)
				rx_rp_q <= ptr_inc(rx_rp_q, rx_depth_q);
			if (rx_in && !pop_ok)
				rx_cnt_q <= 9'(rx_cnt_q + 9'h001);
			else if (!rx_in && pop_ok)
				rx_cnt_q <= 9'(rx_cnt_q - 9'h001);
			if (rx_take) begin
				pkt_len_q <= 9'(pkt_len_q + 9'h001);
				pkt_ep_q  <= rx_word_i.ep;
				if (rx_word_i.last)
					status_pend_q <= 1'b1;
			end
			if (status_wr) begin
				status_pend_q <= 1'b0;
				pkt_len_q     <= 9'h000;
			end
		end
	end

	// transmit fifos; flush select of 5'h10, bit 4 alone set, empties every one
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < NF; i++) begin
				tx_wp_q[i]  <= 9'h000;
				tx_rp_q[i]  <= 9'h000;
				tx_cnt_q[i] <= 9'h000;
			end
		end else begin
			for (int i = 0; i < NF; i++) begin
				if (tx_flush_q && (flush_sel_q == `TX_SEL_ALL ||
				    flush_sel_q == 5'(i))) begin
					tx_wp_q[i]  <= 9'h000;
					tx_rp_q[i]  <= 9'h000;
					tx_cnt_q[i] <= 9'h000;
				end else begin
					if (sw_push && sel == 3'(i))
						tx_wp_q[i] <= ptr_inc(tx_wp_q[i], tx_cfg_q[i].depth);
					if (tx_take && tsel == 3'(i))
						tx_rp_q[i] <= ptr_inc(tx_rp_q[i], tx_cfg_q[i].depth);
					if ((sw_push && sel == 3'(i)) &&
					    !(tx_take && tsel == 3'(i)))
						tx_cnt_q[i] <= 9'(tx_cnt_q[i] + 9'h001);
					else if (!(sw_push && sel == 3'(i)) &&
					         (tx_take && tsel == 3'(i)))
						tx_cnt_q[i] <= 9'(tx_cnt_q[i] - 9'h001);
				end
			end
		end
	end

	// flush bits self clear after one cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_flush_q  <= 1'b0;
			tx_flush_q  <= 1'b0;
			flush_sel_q <= 5'h00;
		end else if (wr_hit_rst && !flushing) begin
			rx_flush_q  <= reg_wdata_i[`RST_RX_FLUSH];
			tx_flush_q  <= reg_wdata_i[`RST_TX_FLUSH];
			flush_sel_q <= reg_wdata_i[`RST_SEL_LO +: 5];
		end else begin
			rx_flush_q <= 1'b0;
			tx_flush_q <= 1'b0;
		end
	end

	// sticky status flags: a new event wins over a clear in the same cycle
	wire mismatch_ev = (wr_hit_push && !sel_ok) || (wr_hit_ep && is_host);
	wire role_chg_ev = role_valid_q && (pin_host != is_host);
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mismatch_q <= 1'b0;
			role_chg_q <= 1'b0;
		end else begin
			mismatch_q <= mismatch_ev || (mismatch_q &&
			              !(wr_hit_stat && reg_wdata_i[`ST_MISMATCH]));
			role_chg_q <= role_chg_ev || (role_chg_q &&
			              !(wr_hit_stat && reg_wdata_i[`ST_ROLE_CHG]));
		end
	end

	// suspend after a continuous idle line with the stop bit set
	logic [19:0] idle_cnt_q;
	logic        suspended_q;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_cnt_q  <= 20'h00000;
			suspended_q <= 1'b0;
		end else if (line_act || !stop_phy_clock_bit) begin
			idle_cnt_q  <= 20'h00000;
			suspended_q <= 1'b0;
		end else if (32'(idle_cnt_q) >= SUSPEND_CYCLES - 1) begin
			suspended_q <= 1'b1;
		end else begin
			idle_cnt_q <= 20'(idle_cnt_q + 20'h00001);
		end
	end

	// frame start: host counts its own frames, device follows tokens
	logic [19:0] frame_cnt_q;
	wire frame_wrap = 32'(frame_cnt_q) >= FRAME_CYCLES - 1;
	wire sof_ev = is_host ? (frame_wrap && !suspended_q) : sof_token_i;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_cnt_q               <= 20'h00000;
			frame_start_pulse_pin_o   <= 1'b0;
			sof_timer_pulse_o         <= 1'b0;
			output_enable_pulse_pin_o <= 1'b0;
		end else begin
			frame_cnt_q <= (frame_wrap || !is_host) ? 20'h00000 :
			               20'(frame_cnt_q + 20'h00001);
			frame_start_pulse_pin_o   <= sof_ev;
			sof_timer_pulse_o         <= sof_ev;
			output_enable_pulse_pin_o <= tx_drive_i;
		end
	end

	assign host_role_o      = is_host;
	assign link_low_speed_o = is_host && usb_cfg_q[`USB_CFG_LS_BIT];
	assign phy_rx_enable_o  = !phy_receive_off_bit;
	assign suspend_o        = suspended_q;

	// register read path, data stand in the cycle after the strobe
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`ST_ROLE]      = is_host;
		status_word[`ST_MISMATCH]  = mismatch_q;
		status_word[`ST_ROLE_CHG]  = role_chg_q;
		status_word[`ST_SUSPEND]   = suspended_q;
		status_word[`ST_ALLOC_ERR] = alloc_err;
		status_word[`ST_RX_AVAIL]  = rx_cnt_q != 9'h000;
		status_word[`ST_LOW_SPEED] = link_low_speed_o;
	end
	// device: seven in and seven out beside endpoint 0; host: channels
	wire [31:0] info_word = is_host ? {19'h0, `HOST_CHANNELS, 8'h00} :
	                        {24'h0, `DEV_OUT_EPS, `DEV_IN_EPS};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_addr_i)
			`OFS_GBUS_CFG:   rd_mux = gbus_cfg_q;
			`OFS_USB_CFG:    rd_mux = usb_cfg_q;
			`OFS_RESET_CTL:  rd_mux = {21'h0, flush_sel_q, tx_flush_q,
			                           rx_flush_q, 4'h0};
			`OFS_IRQ_MASK:   rd_mux = irq_mask_q;
			`OFS_IRQ_STATUS: rd_mux = status_word;
			`OFS_RX_SIZE:    rd_mux = {23'h0, rx_depth_q};
			`OFS_TX_SELECT:  rd_mux = {28'h0, tx_select_q};
			`OFS_CORE_CFG:   rd_mux = {31'h0, phy_receive_off_bit};
			`OFS_PHY_GATE:   rd_mux = {31'h0, stop_phy_clock_bit};
			`OFS_EP_CTL:     rd_mux = {16'h0, ep_nak_q, ep_enable_q};
			`OFS_INFO:       rd_mux = info_word;
			default: begin
				if (reg_addr_i[7:5] == 3'h2 && reg_addr_i[1:0] == 2'h0)
					rd_mux = {7'h0, tx_cfg_q[txsz_idx].depth, 7'h0,
					          tx_cfg_q[txsz_idx].start};
			end
		endcase
	end

	logic [31:0] rdata_q;
	logic        pop_q;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q    <= 32'h0000_0000;
			pop_q      <= 1'b0;
			tx_valid_o <= 1'b0;
		end else begin
			rdata_q    <= reg_rd_i ? rd_mux : 32'h0000_0000;
			pop_q      <= pop_ok;
			tx_valid_o <= tx_take;
		end
	end
	assign reg_rdata_o = pop_q ? mem_rdata : rdata_q;
	assign tx_data_o   = tx_valid_o ? mem_rdata : 32'h0000_0000;
endmodule // usb_dual_role_core

// file: usb_dual_role_monitor.sv
// checker for the usb dual role core: pulses, role, suspend, replies
// assumes it is bound to the core and shares its single clock
`timescale 1ns/1ns
`include "usb_dr_params.svh"
module usb_dual_role_monitor #(
	parameter int SUSPEND_CYCLES = 30000,
	parameter int FRAME_CYCLES   = 10000
) (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        line_activity_pin_i,
	input wire logic        rx_ready_o,
	input wire logic        tx_rd_i,
	input wire logic        tx_valid_o,
	input wire logic        tx_drive_i,
	input wire logic        sof_token_i,
	input wire logic        frame_start_pulse_pin_o,
	input wire logic        sof_timer_pulse_o,
	input wire logic        output_enable_pulse_pin_o,
	input wire logic        host_role_o,
	input wire logic        phy_rx_enable_o,
	input wire logic        suspend_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0]  up_q;
	logic [31:0] idle_q;
	logic        act_q;
	// raw pin quiet time never lags the core's synchronised count
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			up_q <= 2'h0;
			idle_q <= 32'h0;
			act_q <= 1'b0;
		end else begin
			up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
			idle_q <= (act_q != line_activity_pin_i) ? 32'h0 : idle_q + 32'h1;
			act_q <= line_activity_pin_i;
		end
	end
	sequence s_info_read;
		reg_rd_i && reg_addr_i == `OFS_INFO;
	endsequence
	sequence s_wake;
		suspend_o && $changed(line_activity_pin_i);
	endsequence
	chk_oe_follow: assert property (
		output_enable_pulse_pin_o == $past(tx_drive_i)) else $error("oe late");
	chk_sof_device: assert property (
		sof_token_i && !host_role_o |=> frame_start_pulse_pin_o)
		else $error("frame pulse missing");
	chk_sof_timer: assert property (
		frame_start_pulse_pin_o == sof_timer_pulse_o) else $error("timer pulse");
	chk_phy_off: assert property (!phy_rx_enable_o |-> !rx_ready_o)
		else $error("receive with phy off");
	chk_info_read: assert property (s_info_read |=>
		reg_rdata_o == (host_role_o ? 32'h0000_1000 : 32'h0000_0077))
		else $error("info word wrong");
	chk_role_fixed: assert property (up_q == 2'h3 |-> $stable(host_role_o))
		else $error("role moved");
	chk_wake_up: assert property (s_wake |-> ##[1:5] !suspend_o)
		else $error("no wake on activity");
	chk_idle_wait: assert property (
		$rose(suspend_o) |-> idle_q >= 32'(SUSPEND_CYCLES))
		else $error("suspend too early");
	chk_tx_answer: assert property (tx_valid_o |-> $past(tx_rd_i))
		else $error("tx word without request");
endmodule // usb_dual_role_monitor

bind usb_dual_role_core usb_dual_role_monitor #(
	.SUSPEND_CYCLES(SUSPEND_CYCLES), .FRAME_CYCLES(FRAME_CYCLES)
) u_monitor (.*);

// file: usb_peer_model.sv
// usb peer model: hands received words to the core, moves the lines
// assumes the core clock and a combinational ready from the core
`timescale 1ns/1ns
module usb_peer_model (
	input  wire logic            core_clk_i,
	input  wire logic            rx_ready_i,
	output logic                 rx_valid_o,
	output usb_dr_pkg::rx_word_t rx_word_o,
	output logic                 line_act_o
);
	initial begin
		rx_valid_o = 1'b0;
		rx_word_o = '0;
		line_act_o = 1'b0;
	end
	// ready is read at the falling edge, where the core's flops are settled
	task automatic send(input logic [31:0] d, input logic last,
		input logic [3:0] ep, input int stall);
		logic ok;
		int   n;
		ok = 1'b0;
		n = 0;
		if (stall > 0) begin
			rx_valid_o <= 1'b0;
			rx_word_o <= ~rx_word_o;
			repeat (stall) @(posedge core_clk_i);
		end
		rx_valid_o <= 1'b1;
		rx_word_o <= '{data: d, last: last, ep: ep};
		line_act_o <= ~line_act_o;
		while (!ok && n < 100) begin
			@(negedge core_clk_i);
			ok = rx_ready_i;
			@(posedge core_clk_i);
			n++;
		end
	endtask
	// a released bus shows the inverse, never a stale word
	task automatic release_bus();
		rx_valid_o <= 1'b0;
		rx_word_o <= ~rx_word_o;
	endtask
	task automatic toggle();
		line_act_o <= ~line_act_o;
	endtask
endmodule // usb_peer_model

// file: usb_dual_role_fifo_setup_tb.sv
// self-checking bench for the usb dual role core with a usb peer model
// assumes shortened suspend and frame counts and one 10 MHz clock
`timescale 1ns/1ns
`include "usb_dr_params.svh"
module usb_dual_role_fifo_setup_tb;
	localparam int SUSP = 20;
	localparam int FRAME = 16;
	logic        core_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        role_pin = 1'b1;
	logic        tx_rd_i = 1'b0;
	logic [3:0]  tx_sel_i = 4'h3;
	logic        tx_drive_i = 1'b0;
	logic        sof_token_i = 1'b0;
	logic [31:0] reg_rdata_o, tx_data_o, v, exp_q[$];
	logic        rx_valid, rx_ready_o, act, tx_rd_ready_o, tx_valid_o;
	logic        frame_pin, timer_pin, oe_pin, host_role_o, low_speed;
	logic        phy_rx_enable_o, suspend_o;
	logic [31:0] seed = 32'h3D36_700B;
	int          err_count = 0;
	int          compares = 0;
	usb_dr_pkg::rx_word_t rx_word;
	always #50 core_clk_i = ~core_clk_i;
	usb_dual_role_core #(.SUSPEND_CYCLES(SUSP), .FRAME_CYCLES(FRAME)) uut (
		.*, .role_select_pin_i(role_pin), .line_activity_pin_i(act),
		.rx_valid_i(rx_valid), .rx_word_i(rx_word), .link_low_speed_o(low_speed),
		.frame_start_pulse_pin_o(frame_pin), .sof_timer_pulse_o(timer_pin),
		.output_enable_pulse_pin_o(oe_pin));
	usb_peer_model peer (.core_clk_i(core_clk_i), .rx_ready_i(rx_ready_o),
		.rx_valid_o(rx_valid), .rx_word_o(rx_word), .line_act_o(act));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pin(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		cmp(reg_rdata_o & m, e);
		@(posedge core_clk_i);
	endtask
	task automatic reset_to(input logic role);
		rst_i <= 1'b1;
		role_pin <= role;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(negedge core_clk_i);
		@(negedge core_clk_i);
		pin(host_role_o, !role);
		@(posedge core_clk_i);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin : main
		int i, n, ep;
		logic [31:0] d;
		reset_to(1'b1);
		pin(phy_rx_enable_o, 1'b1);
		pin(tx_rd_ready_o, 1'b1);
		rdc(`OFS_EP_CTL, 32'h0000_FF00, '1);
		rdc(`OFS_INFO, 32'h0000_0077, '1);
		rdc(8'h3C, 32'h0, '1);
		wr(`OFS_CORE_CFG, 32'h1);
		pin(phy_rx_enable_o, 1'b0);
		wr(`OFS_CORE_CFG, 32'h0);
		wr(`OFS_GBUS_CFG, 32'hFFFF_FFFF);
		rdc(`OFS_GBUS_CFG, `GBUS_CFG_MASK, '1);
		wr(`OFS_USB_CFG, 32'h0001_2403);
		pin(low_speed, 1'b0);
		rdc(`OFS_USB_CFG, 32'h0000_2403, 32'h3C07);
		wr(`OFS_RX_SIZE, 32'h40);
		for (i = 0; i < 8; i++) begin
			wr(`OFS_TX_SIZE0 + 8'(4 * i), {16'h10, 16'(64 + 16 * i)});
		end
		rdc(`OFS_TX_SIZE0 + 8'h4, 32'h0010_0050, '1);
		wr(`OFS_TX_SIZE0 + 8'h1C, 32'h0020_012C);
		rdc(`OFS_IRQ_STATUS, 32'h10, 32'h10);
		wr(`OFS_TX_SIZE0 + 8'h1C, 32'h0010_0130);
		rdc(`OFS_IRQ_STATUS, 32'h0, 32'h10);
		wr(`OFS_EP_CTL, 32'h0000_FF01);
		wr(`OFS_RX_SIZE, 32'h20);
		rdc(`OFS_RX_SIZE, 32'h40, '1);
		wr(`OFS_EP_CTL, 32'h0000_FF00);
		wr(`OFS_RESET_CTL, 32'h0000_0430);
		repeat (4) @(posedge core_clk_i);
		rdc(`OFS_RESET_CTL, 32'h0, 32'h30);
		for (i = 0; i < 3; i++) begin
			n = 1 + (rnd() % 4);
			ep = rnd() % 8;
			for (int k = 0; k < n; k++) begin
				d = rnd();
				exp_q.push_back(d);
				peer.send(d, k == n - 1, 4'(ep), k % 2);
			end
			exp_q.push_back({19'h0, 9'(n), 4'(ep)});
		end
		peer.release_bus();
		@(posedge core_clk_i);
		rdc(`OFS_IRQ_STATUS, 32'h20, 32'h20);
		while (exp_q.size() > 0) begin
			rdc(`OFS_RX_POP, exp_q.pop_front(), '1);
		end
		rdc(`OFS_IRQ_STATUS, 32'h0, 32'h20);
		wr(`OFS_TX_SELECT, 32'h3);
		for (i = 0; i < 2; i++) begin
			d = rnd();
			exp_q.push_back(d);
			wr(`OFS_TX_PUSH, d);
		end
		for (i = 0; i < 3; i++) begin
			tx_rd_i <= 1'b1;
			@(posedge core_clk_i);
			tx_rd_i <= 1'b0;
			@(negedge core_clk_i);
			cmp(tx_data_o, i < 2 ? exp_q.pop_front() : 32'h0);
			@(posedge core_clk_i);
		end
		sof_token_i <= 1'b1;
		tx_drive_i <= 1'b1;
		@(posedge core_clk_i);
		sof_token_i <= 1'b0;
		tx_drive_i <= 1'b0;
		@(negedge core_clk_i);
		pin(timer_pin, 1'b1);
		pin(oe_pin, 1'b1);
		@(posedge core_clk_i);
		peer.toggle();
		wr(`OFS_PHY_GATE, 32'h1);
		for (n = 0; n < SUSP + 20 && suspend_o !== 1'b1; n++) begin
			@(negedge core_clk_i);
		end
		pin(n >= SUSP - 4, 1'b1);
		@(posedge core_clk_i);
		rdc(`OFS_IRQ_STATUS, 32'h8, 32'h8);
		peer.toggle();
		repeat (6) @(posedge core_clk_i);
		pin(suspend_o, 1'b0);
		wr(`OFS_PHY_GATE, 32'h0);
		reset_to(1'b0);
		rdc(`OFS_INFO, 32'h0000_1000, '1);
		wr(`OFS_USB_CFG, 32'h0001_2403);
		pin(low_speed, 1'b1);
		n = 0;
		repeat (4 * FRAME) begin
			@(negedge core_clk_i);
			n += int'(frame_pin);
		end
		cmp(32'(n), 32'h4);
		@(posedge core_clk_i);
		wr(`OFS_TX_SELECT, 32'h2);
		wr(`OFS_TX_PUSH, 32'h5);
		rdc(`OFS_IRQ_STATUS, 32'h2, 32'h2);
		role_pin <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		rdc(`OFS_IRQ_STATUS, 32'h5, 32'h5);
		tally_and_finish();
	end
	initial begin : watchdog
		repeat (4000) @(posedge core_clk_i);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule // usb_dual_role_fifo_setup_tb
